/* File: rtl/scm_pkg.sv */
package scm_pkg;

	// Byte offsets of the three registers, each in byte lane 0 of its own word.
	localparam logic [3:0] ADDR_MODE  = 4'h0;
	localparam logic [3:0] ADDR_IDLE  = 4'h4;
	localparam logic [3:0] ADDR_RADIO = 4'h8;

	// Field positions in system_mode_control.
	localparam int MODE_CKS_LSB = 5;
	localparam int MODE_FST     = 4;
	localparam int MODE_LRDY    = 3;
	localparam int MODE_HRDY    = 2;
	localparam int MODE_IDLE    = 1;
	localparam int MODE_HL      = 0;

	// Field positions in idle_clock_and_reset_flags.
	localparam int IDLE_KEEP = 7;
	localparam int FLG_LV    = 2;
	localparam int FLG_LVC   = 1;
	localparam int FLG_WD    = 0;

	// Field positions in radio_clock_output_control.
	localparam int RAD_EN     = 4;
	localparam int RAD_SR_LSB = 0;

	// Reset values of the writable fields.
	localparam logic [2:0] RST_CKS  = 3'h6;
	localparam logic       RST_FST  = 1'h0;
	localparam logic       RST_IDLE = 1'h1;
	localparam logic       RST_HL   = 1'h0;
	localparam logic       RST_KEEP = 1'h0;
	localparam logic       RST_FLAG = 1'h0;
	localparam logic       RST_REN  = 1'h0;
	localparam logic [1:0] RST_SR   = 2'h0;

	// Oscillator cycles until a restarted oscillator counts as stable.
	localparam logic [10:0] HXT_RDY_CYC  = 11'h400;
	localparam logic [10:0] LXT_RDY_CYC  = 11'h400;
	localparam logic [10:0] LOW_RC_OSC_RDY_CYC = 11'h002;

	// Source codes of the clock multiplexer; 2 to 7 are the divided high clock.
	localparam logic [3:0] SRC_NONE = 4'h0;
	localparam logic [3:0] SRC_SUB  = 4'h1;
	localparam logic [3:0] SRC_DIV2 = 4'h7;
	localparam logic [3:0] SRC_HIGH = 4'h8;
	localparam logic [2:0] CKS_DIV_MIN = 3'h2;

	typedef enum logic [2:0] {
		PM_RUN,
		PM_WAKE,
		PM_FAST,
		PM_IDLE_SYS,
		PM_IDLE_NO,
		PM_SLEEP_SUB,
		PM_DEEP
	} scm_mode_e;

	typedef struct packed {
		logic [2:0] cks;
		logic       fst;
		logic       idle;
		logic       hl;
	} scm_modereg_s;

	typedef struct packed {
		logic keep;
		logic lv;
		logic lvc;
		logic wd;
	} scm_flagreg_s;

	typedef struct packed {
		logic       en;
		logic [1:0] sr;
	} scm_radioreg_s;

endpackage

/* File: rtl/scm_clock_mode.sv */
`timescale 1ns/1ps

// Function
// - Divider field picks sub clock for 000/001, high clock /64 down to /2 after.
// - High clock select set gives the undivided high clock as system clock.
// - Moving the system clock to the sub clock stops the high oscillator unless the radio output is enabled.
// - With fast wake-up and high source, sub clock runs the system after wake.
// - Low ready flag is low in deep sleep, rises after 2 or 1024 cycles.
// - High ready flag clear at power-on, low when stopped, rises after 1024 cycles.
// - HALT with idle bit enters idle, keeping or stopping sysclk; otherwise sleep.
// - Low-voltage reset flag set by hardware, cleared only by software writing 0.
// - Level register undefined value sets its flag; only software clears it.
// - Watchdog control reset sets its flag; only software clears it.
// - Unimplemented bits of flag and radio registers read as zero.
// - Radio clock output is gated by its enable bit; software keeps it enabled.
// - Two-bit slew field selects edge rate, 00 fastest, 11 slowest.
// - Fast wake-up works only from sleep-with-subclock or idle-without-sysclk.
// - Fast wake runs on sub clock until 1024 crystal cycles, then switches.
// - Low-speed source wake waits 1024 or 2 cycles; fast wake-up ignored.
// - Deep-sleep wake never uses sub clock; waits for original oscillator.
// - HALT without idle: deep sleep only if detector and watchdog off.
// - Changeover to the sub clock waits for the low ready flag.
module scm_clock_mode
	import scm_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        hxt_clk_pin,
	input  wire logic        sub_clk_pin,
	input  wire logic        sub_is_lxt,
	input  wire logic        halt_req,
	input  wire logic        wakeup_req,
	input  wire logic        lowvolt_detect_enable,
	input  wire logic        watchdog_enable,
	input  wire logic        lowvolt_reset_event,
	input  wire logic        lowvolt_level_register_undefined_event,
	input  wire logic        watchdog_ctrl_reset_event,
	output logic             sys_clock_out,
	output logic             cpu_clock_enable,
	output logic             periph_clock_enable,
	output logic             high_crystal_osc_enable,
	output logic             sub_osc_enable,
	output logic             radio_clock_output,
	output logic      [1:0]  output_slew_select,
	output scm_mode_e        power_mode
);

	// Every flip-flop of the block sits in this one record, so reset and
	// registering stay in a single place and no field can be forgotten.
	typedef struct packed {
		logic [2:0]    hsync;
		logic [2:0]    lsync;
		logic          hlvl;
		logic          llvl;
		logic [5:0]    dcnt;
		logic [10:0]   hcnt;
		logic [10:0]   lcnt;
		logic          high_osc_ready;
		logic          low_osc_ready;
		scm_mode_e     mode;
		logic [3:0]    act;
		logic          fsys;
		scm_modereg_s  mr;
		scm_flagreg_s  fr;
		scm_radioreg_s rr;
		logic          wait_n;
		logic [7:0]    rdata;
		logic          cpu_en;
		logic          per_en;
		logic          hxt_en;
		logic          sub_en;
		logic          rclk;
	} scm_state_s;

	// Registered state and its next value, filled by the combinational process.
	scm_state_s s_ff;
	scm_state_s nxt_s;

	// Register decode shared by the bus read path.
	function automatic logic [7:0] rd_byte(input logic [3:0] a, input scm_state_s s);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			ADDR_MODE: begin
				v[MODE_CKS_LSB +: 3] = s.mr.cks;
				v[MODE_FST]          = s.mr.fst;
				v[MODE_LRDY]         = s.low_osc_ready;
				v[MODE_HRDY]         = s.high_osc_ready;
				v[MODE_IDLE]         = s.mr.idle;
				v[MODE_HL]           = s.mr.hl;
			end
			ADDR_IDLE: begin
				v[IDLE_KEEP] = s.fr.keep;
				v[FLG_LV]    = s.fr.lv;
				v[FLG_LVC]   = s.fr.lvc;
				v[FLG_WD]    = s.fr.wd;
			end
			ADDR_RADIO: begin
				v[RAD_EN]           = s.rr.en;
				v[RAD_SR_LSB +: 2]  = s.rr.sr;
			end
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// Source that the software fields ask for.
	function automatic logic [3:0] want_code(input logic hl, input logic [2:0] cks);
		logic [3:0] c;
		c = SRC_SUB;
		if (hl) begin
			c = SRC_HIGH;
		end else if (cks >= CKS_DIV_MIN) begin
			c = {1'b0, cks};
		end
		return c;
	endfunction

	// Present level of one multiplexer input.
	// Divider bit 0 is the /2 tap, so code 7 reads bit 0 and code 2 reads bit 5.
	function automatic logic src_level(input logic [3:0] c, input scm_state_s s);
		logic l;
		l = 1'b0;
		if (c == SRC_SUB) begin
			l = s.llvl;
		end else if (c == SRC_HIGH) begin
			l = s.hlvl;
		end else if (c != SRC_NONE) begin
			l = s.dcnt[3'(SRC_DIV2 - c)];
		end
		return l;
	endfunction

	// A hardware-set flag: a software write of 0 clears, an event in the same
	// cycle wins so it is never lost, and a write of 1 leaves the flag alone.
	function automatic logic flag_upd(input logic cur, input logic wr, input logic d,
			input logic ev);
		return (cur & ~(wr & ~d)) | ev;
	endfunction

	// Helpers of the combinational process; each is written on every pass, so
	// none of them holds a value from one cycle to the next.
	logic [3:0] want;
	logic       want_hi;
	logic       want_rdy;
	logic       hrise;
	logic       lrise;
	logic [3:0] tgt;
	logic       acc;
	logic       wr_mode;
	logic       wr_idle;
	logic       wr_radio;
	logic [7:0] wd;
	logic [10:0] lrdy_lim;
	logic       awake;

	always_comb begin
		nxt_s = s_ff;

		// Pin clocks pass three stages; a level counts once stages two and three agree.
		nxt_s.hsync = {s_ff.hsync[1:0], hxt_clk_pin};
		nxt_s.lsync = {s_ff.lsync[1:0], sub_clk_pin};
		if (s_ff.hsync[1] == s_ff.hsync[2]) begin
			nxt_s.hlvl = s_ff.hsync[2];
		end
		if (s_ff.lsync[1] == s_ff.lsync[2]) begin
			nxt_s.llvl = s_ff.lsync[2];
		end
		hrise = nxt_s.hlvl & ~s_ff.hlvl;
		lrise = nxt_s.llvl & ~s_ff.llvl;

		// Ripple of the high clock divider; bit 0 is the high clock halved.
		if (hrise) begin
			nxt_s.dcnt = s_ff.dcnt + 6'h01;
		end

		// Requested source and whether it has proven itself stable. A high source
		// waits for the crystal count and the sub clock for the low count.
		want     = want_code(s_ff.mr.hl, s_ff.mr.cks);
		want_hi  = (want != SRC_SUB);
		want_rdy = want_hi ? s_ff.high_osc_ready : s_ff.low_osc_ready;
		lrdy_lim = sub_is_lxt ? LXT_RDY_CYC : LOW_RC_OSC_RDY_CYC;

		// Stability counts restart whenever an oscillator is held stopped.
		if (!s_ff.hxt_en) begin
			nxt_s.hcnt = 11'h000;
			nxt_s.high_osc_ready  = 1'b0;
		end else if (hrise && !s_ff.high_osc_ready) begin
			nxt_s.hcnt = s_ff.hcnt + 11'h001;
			nxt_s.high_osc_ready  = (nxt_s.hcnt == HXT_RDY_CYC);
		end
		if (!s_ff.sub_en) begin
			nxt_s.lcnt = 11'h000;
			nxt_s.low_osc_ready  = 1'b0;
		end else if (lrise && !s_ff.low_osc_ready) begin
			nxt_s.lcnt = s_ff.lcnt + 11'h001;
			nxt_s.low_osc_ready  = (nxt_s.lcnt >= lrdy_lim);
		end

		// Power mode sequencing on HALT and wake-up.
		// HALT is only heard in RUN; one seen during a fast wake is dropped.
		unique case (s_ff.mode)
			PM_RUN: begin
				if (halt_req) begin
					if (s_ff.mr.idle) begin
						nxt_s.mode = s_ff.fr.keep ? PM_IDLE_SYS : PM_IDLE_NO;
					end else if (lowvolt_detect_enable || watchdog_enable) begin
						nxt_s.mode = PM_SLEEP_SUB;
					end else begin
						nxt_s.mode = PM_DEEP;
					end
				end
			end
			PM_IDLE_SYS: begin
				if (wakeup_req) begin
					nxt_s.mode = PM_RUN;
				end
			end
			PM_IDLE_NO, PM_SLEEP_SUB: begin
				if (wakeup_req) begin
					if (want_hi && s_ff.mr.fst) begin
						nxt_s.mode = PM_FAST;
					end else begin
						nxt_s.mode = PM_WAKE;
					end
					if (!want_hi) begin
						// A low-speed source re-proves itself; fast wake is ignored.
						nxt_s.lcnt = 11'h000;
						nxt_s.low_osc_ready  = 1'b0;
					end
				end
			end
			PM_DEEP: begin
				if (wakeup_req) begin
					nxt_s.mode = PM_WAKE;
				end
			end
			PM_WAKE: begin
				if (want_rdy) begin
					nxt_s.mode = PM_RUN;
				end
			end
			PM_FAST: begin
				if (s_ff.high_osc_ready) begin
					nxt_s.mode = PM_RUN;
				end
			end
			default: begin
				nxt_s.mode = PM_WAKE; // An illegal code recovers by waiting for the source.
			end
		endcase

		// Multiplexer target; a source is only taken once it is proven stable.
		// In every stopped mode the target is no source, so the output rests low.
		unique case (s_ff.mode)
			PM_RUN:      tgt = want_rdy ? want : s_ff.act;
			PM_IDLE_SYS: tgt = s_ff.act;
			PM_FAST:     tgt = SRC_SUB;
			default:     tgt = SRC_NONE;
		endcase

		// Swap only while both the output and the new input are low, so no
		// pulse is cut short; the price is a low phase stretched by one swap.
		if (tgt != s_ff.act && !s_ff.fsys && !src_level(tgt, s_ff)) begin
			nxt_s.act = tgt;
		end
		nxt_s.fsys = src_level(nxt_s.act, s_ff);

		// Enables follow the next mode so the outputs stay registered.
		awake = (nxt_s.mode == PM_RUN) || (nxt_s.mode == PM_WAKE) ||
			(nxt_s.mode == PM_FAST) || (nxt_s.mode == PM_IDLE_SYS);
		nxt_s.cpu_en = (nxt_s.mode == PM_RUN) || (nxt_s.mode == PM_FAST);
		nxt_s.per_en = nxt_s.cpu_en || (nxt_s.mode == PM_IDLE_SYS);
		// The crystal stays up for the radio while its output is enabled.
		// A limitation: with the radio output on, the crystal never stops, so the
		// high ready flag stays set through sleep as well.
		nxt_s.hxt_en = (awake && (want_hi || (s_ff.act >= 4'h2))) || s_ff.rr.en;
		nxt_s.sub_en = (nxt_s.mode != PM_DEEP);
		nxt_s.rclk   = s_ff.rr.en & s_ff.hlvl;

		// Avalon slave: one wait cycle, then the access completes.
		acc = (avs_read || avs_write) && !s_ff.wait_n;
		if ((avs_read || avs_write) && s_ff.wait_n) begin
			nxt_s.wait_n = 1'b0;
			nxt_s.rdata  = rd_byte(avs_address, s_ff);
		end else begin
			nxt_s.wait_n = 1'b1;
		end
		// Writes land at the edge where the master sees waitrequest low; only byte
		// lane 0 carries register bits.
		wd       = avs_writedata[7:0];
		wr_mode  = acc && avs_write && avs_byteenable[0] && (avs_address == ADDR_MODE);
		wr_idle  = acc && avs_write && avs_byteenable[0] && (avs_address == ADDR_IDLE);
		wr_radio = acc && avs_write && avs_byteenable[0] && (avs_address == ADDR_RADIO);

		if (wr_mode) begin
			nxt_s.mr.cks  = wd[MODE_CKS_LSB +: 3];
			nxt_s.mr.fst  = wd[MODE_FST];
			nxt_s.mr.idle = wd[MODE_IDLE];
			nxt_s.mr.hl   = wd[MODE_HL];
		end
		if (wr_idle) begin
			nxt_s.fr.keep = wd[IDLE_KEEP];
		end
		if (wr_radio) begin
			nxt_s.rr.en = wd[RAD_EN];
			nxt_s.rr.sr = wd[RAD_SR_LSB +: 2];
		end

		// Reset-cause flags.
		nxt_s.fr.lv  = flag_upd(s_ff.fr.lv, wr_idle, wd[FLG_LV], lowvolt_reset_event);
		nxt_s.fr.lvc = flag_upd(s_ff.fr.lvc, wr_idle, wd[FLG_LVC],
			lowvolt_level_register_undefined_event);
		nxt_s.fr.wd  = flag_upd(s_ff.fr.wd, wr_idle, wd[FLG_WD],
			watchdog_ctrl_reset_event);
	end

	// All state in one register; power-on starts waiting for the crystal.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_ff.hsync   <= 3'h0;
			s_ff.lsync   <= 3'h0;
			s_ff.hlvl    <= 1'b0;
			s_ff.llvl    <= 1'b0;
			s_ff.dcnt    <= 6'h00;
			s_ff.hcnt    <= 11'h000;
			s_ff.lcnt    <= 11'h000;
			s_ff.high_osc_ready     <= 1'b0;
			s_ff.low_osc_ready     <= 1'b0;
			s_ff.mode    <= PM_WAKE;
			s_ff.act     <= SRC_NONE;
			s_ff.fsys    <= 1'b0;
			s_ff.mr.cks  <= RST_CKS;
			s_ff.mr.fst  <= RST_FST;
			s_ff.mr.idle <= RST_IDLE;
			s_ff.mr.hl   <= RST_HL;
			s_ff.fr.keep <= RST_KEEP;
			s_ff.fr.lv   <= RST_FLAG;
			s_ff.fr.lvc  <= RST_FLAG;
			s_ff.fr.wd   <= RST_FLAG;
			s_ff.rr.en   <= RST_REN;
			s_ff.rr.sr   <= RST_SR;
			s_ff.wait_n  <= 1'b1;
			s_ff.rdata   <= 8'h00;
			s_ff.cpu_en  <= 1'b0;
			s_ff.per_en  <= 1'b0;
			s_ff.hxt_en  <= 1'b1;
			s_ff.sub_en  <= 1'b1;
			s_ff.rclk    <= 1'b0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs taken straight from the state register.
	assign avs_readdata            = {24'h000000, s_ff.rdata};
	assign avs_waitrequest         = s_ff.wait_n;
	assign sys_clock_out           = s_ff.fsys;
	assign cpu_clock_enable        = s_ff.cpu_en;
	assign periph_clock_enable     = s_ff.per_en;
	assign high_crystal_osc_enable = s_ff.hxt_en;
	assign sub_osc_enable          = s_ff.sub_en;
	assign radio_clock_output      = s_ff.rclk;
	assign output_slew_select      = s_ff.rr.sr;
	assign power_mode              = s_ff.mode;

endmodule

/* File: verification/scm_osc_model.sv */
`timescale 1ns/1ps

// Crystal and sub oscillators; a stopped oscillator holds its line low.
module scm_osc_model (
	input  wire logic hxt_en,
	input  wire logic sub_en,
	output logic      hxt_clk,
	output logic      sub_clk
);
	// Crystal period 86 ns, well below a sixth of the system clock rate.
	initial begin
		hxt_clk = 1'b0;
		forever begin
			#43;
			hxt_clk = hxt_en ? ~hxt_clk : 1'b0;
		end
	end
	// Sub clock period 120 ns, short so a full 1024-cycle count fits the run.
	initial begin
		sub_clk = 1'b0;
		forever begin
			#60;
			sub_clk = sub_en ? ~sub_clk : 1'b0;
		end
	end
endmodule

/* File: verification/scm_clock_mode_chk.sv */
`timescale 1ns/1ps

// Bus handshake and power-mode relations seen at the controller ports.
module scm_clock_mode_chk
	import scm_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rstn,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        halt_req,
	input wire logic        lowvolt_detect_enable,
	input wire logic        watchdog_enable,
	input wire logic        cpu_clock_enable,
	input wire logic        periph_clock_enable,
	input wire logic        sub_osc_enable,
	input scm_mode_e        power_mode
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// The enables are registered together with the mode; mode is still held two cycles first.
	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("bus answer missing");
	bus_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer longer than one cycle");
	upper_zero_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
		else $error("upper read bits set");
	halt_enter_a: assert property (halt_req && power_mode == PM_RUN
		|=> power_mode inside {PM_IDLE_SYS, PM_IDLE_NO, PM_SLEEP_SUB, PM_DEEP})
		else $error("halt ignored");
	halt_sub_a: assert property (halt_req && power_mode == PM_RUN
		&& (lowvolt_detect_enable || watchdog_enable) |=> power_mode != PM_DEEP)
		else $error("deep sleep with detector on");
	deep_exit_a: assert property (power_mode == PM_DEEP
		|=> power_mode inside {PM_DEEP, PM_WAKE}) else $error("fast exit from deep");
	deep_osc_a: assert property (power_mode == PM_DEEP [*2] |-> !sub_osc_enable)
		else $error("sub clock runs in deep sleep");
	cpu_off_a: assert property (power_mode inside {PM_IDLE_SYS, PM_IDLE_NO,
		PM_SLEEP_SUB, PM_DEEP} [*2] |-> !cpu_clock_enable) else $error("cpu clocked");
	idle_keep_a: assert property (power_mode == PM_IDLE_SYS [*2]
		|-> periph_clock_enable) else $error("idle lost sysclk");
endmodule

bind scm_clock_mode scm_clock_mode_chk chk_u (.sys_clk, .rstn, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .halt_req, .lowvolt_detect_enable, .watchdog_enable,
	.cpu_clock_enable, .periph_clock_enable, .sub_osc_enable, .power_mode);

/* File: verification/system_clock_mode_control_tb_top.sv */
`timescale 1ns/1ps

// Register, divider and power-mode scenarios for the clock controller.
module system_clock_mode_control_tb_top
	import scm_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [4:0]  ev = 5'h0;
	logic [1:0]  lw = 2'h0;
	logic        low_crystal_osc = 1'b0;
	logic        hxt_clk_pin, sub_clk_pin, sys_clock_out, cpu_clock_enable;
	logic        periph_clock_enable, high_crystal_osc_enable, sub_osc_enable;
	logic        radio_clock_output;
	logic [1:0]  output_slew_select;
	scm_mode_e   power_mode;
	logic [7:0]  q;
	int          errors = 0;
	int          comparisons = 0;
	int          cyc = 0;
	logic [7:0]  tm [7] = '{8'hc2, 8'hc0, 8'hc0, 8'hd2, 8'hd0, 8'hd0, 8'h12};
	logic [1:0]  tl [7] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h2, 2'h0, 2'h0};
	scm_mode_e   t1 [7] = '{PM_IDLE_SYS, PM_SLEEP_SUB, PM_DEEP, PM_IDLE_NO, PM_SLEEP_SUB,
		PM_DEEP, PM_IDLE_NO};
	scm_mode_e   t2 [7] = '{PM_RUN, PM_WAKE, PM_WAKE, PM_FAST, PM_FAST, PM_WAKE, PM_WAKE};

	always #5 sys_clk = ~sys_clk;

	scm_clock_mode dut_u (.sys_clk, .rstn, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest,
		.hxt_clk_pin, .sub_clk_pin, .sub_is_lxt(low_crystal_osc), .halt_req(ev[0]),
		.wakeup_req(ev[1]), .lowvolt_detect_enable(lw[1]), .watchdog_enable(lw[0]),
		.lowvolt_reset_event(ev[2]), .lowvolt_level_register_undefined_event(ev[3]),
		.watchdog_ctrl_reset_event(ev[4]), .sys_clock_out, .cpu_clock_enable,
		.periph_clock_enable, .high_crystal_osc_enable, .sub_osc_enable,
		.radio_clock_output, .output_slew_select, .power_mode);
	scm_osc_model osc_u (.hxt_en(high_crystal_osc_enable), .sub_en(sub_osc_enable),
		.hxt_clk(hxt_clk_pin), .sub_clk(sub_clk_pin));

	// One bus access held until the slave answers; read data are taken at that edge.
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t: saw %h, wanted %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h0);
		chk(q, e);
	endtask

	task automatic pulse(input int i);
		@(posedge sys_clk);
		ev[i] <= 1'b1;
		@(posedge sys_clk);
		ev[i] <= 1'b0;
	endtask

	// Oscillator waits are long, so the bound covers a full crystal restart.
	task automatic wait_mode(input scm_mode_e m);
		for (int n = 0; n < 20000 && power_mode !== m; n++) @(posedge sys_clk);
		chk({5'h0, power_mode}, {5'h0, m});
	endtask

	// Counts rising edges of the system clock or the radio clock over n cycles.
	task automatic rises(input int n, input logic radio, output int c);
		logic p;
		logic s;
		c = 0;
		p = 1'b1;
		repeat (n) begin
			@(posedge sys_clk);
			s = radio ? radio_clock_output : sys_clock_out;
			c += int'(s && !p);
			p = s;
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// The slowest path needs about 78000 cycles, so this only cuts a hang short.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			errors++;
			summarize();
		end
	end

	// Main sequence.
	initial begin
		int cnt;
		int d;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		wait_mode(PM_RUN);
		rd(ADDR_MODE, 8'hce);
		rd(ADDR_IDLE, 8'h00);
		rd(ADDR_RADIO, 8'h00);
		wr(4'hc, 8'hff);
		rd(4'hc, 8'h00);
		$display("test reset done");
		for (int i = 0; i < 3; i++) begin
			pulse(2 + i);
			rd(ADDR_IDLE, 8'h04 >> i);
			wr(ADDR_IDLE, 8'h07);
			rd(ADDR_IDLE, 8'h04 >> i);
			wr(ADDR_IDLE, 8'h00);
			rd(ADDR_IDLE, 8'h00);
		end
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_RADIO, 8'hfc | i[7:0]);
			rd(ADDR_RADIO, 8'h10 | i[7:0]);
			chk({6'h0, output_slew_select}, i[7:0]);
		end
		rises(100, 1'b1, cnt);
		chk(8'(cnt > 0), 8'h1);
		wr(ADDR_RADIO, 8'h00);
		repeat (4) @(posedge sys_clk);
		rises(100, 1'b1, cnt);
		chk(8'(cnt), 8'h0);
		$display("test flags done");
		// Undivided crystal first, then divide by 64 down to 2; 80 crystal periods counted.
		for (int i = 1; i < 8; i++) begin
			wr(ADDR_MODE, (i == 1) ? 8'h03 : {i[2:0], 5'h02});
			repeat (700) @(posedge sys_clk);
			rises(688, 1'b0, cnt);
			d = (i == 1) ? 80 : 80 >> (8 - i);
			chk(8'(cnt >= d - 1 && cnt <= d + 1), 8'h1);
		end
		$display("test divider done");
		for (int i = 0; i < 7; i++) begin
			wr(ADDR_MODE, tm[i]);
			wr(ADDR_IDLE, (i == 0) ? 8'h80 : 8'h00);
			lw <= tl[i];
			pulse(0);
			repeat (4) @(posedge sys_clk);
			chk({5'h0, power_mode}, {5'h0, t1[i]});
			repeat (200) @(posedge sys_clk);
			chk(8'(high_crystal_osc_enable), 8'(t1[i] == PM_IDLE_SYS));
			rd(ADDR_MODE, tm[i] | {4'h0, t1[i] != PM_DEEP, t1[i] == PM_IDLE_SYS, 2'h0});
			pulse(1);
			for (int n = 0; n < 300 && power_mode === t1[i]; n++) @(posedge sys_clk);
			chk({5'h0, power_mode}, {5'h0, t2[i]});
			// A fast wake runs on the sub clock; a slow wake keeps the clock stopped.
			if (t2[i] != PM_RUN && i < 6) begin
				rises(240, 1'b0, cnt);
				d = (t2[i] == PM_FAST) ? 20 : 0;
				chk(8'(d > 0 ? cnt >= d - 2 && cnt <= d + 1 : cnt == 0), 8'h1);
			end
			wait_mode(PM_RUN);
			$display("test halt %0d done", i);
		end
		chk(8'(high_crystal_osc_enable), 8'h0);
		// Low crystal as sub source: the wake must wait out the full 1024 count.
		low_crystal_osc <= 1'b1;
		pulse(0);
		repeat (4) @(posedge sys_clk);
		chk({5'h0, power_mode}, {5'h0, PM_IDLE_NO});
		pulse(1);
		repeat (12000) @(posedge sys_clk);
		chk({5'h0, power_mode}, {5'h0, PM_WAKE});
		wait_mode(PM_RUN);
		$display("test slow crystal done");
		summarize();
	end
endmodule
